// ### rsp_consts.vh
// constants for the radio serial status port: header layout, address map,
// status byte layout and event kinds.
// assumes it is included by bare name from the port's design file.
`ifndef RSP_CONSTS_VH
`define RSP_CONSTS_VH

// header byte fields, top bit first
`define RSP_HDR_RW_BIT      7
`define RSP_HDR_BURST_BIT   6
`define RSP_HDR_ADDR_MSB    5

// address map
`define RSP_ADDR_FIFO       6'h3F
`define RSP_ADDR_STAT_LO    6'h30
`define RSP_ADDR_STAT_HI    6'h3D

// status byte layout
`define RSP_ST_READY_BIT    7
`define RSP_ST_STATE_MSB    6
`define RSP_ST_STATE_LSB    4
`define RSP_ST_COUNT_SAT    4'hF

// main state codes
`define RSP_STATE_IDLE      3'h0
`define RSP_STATE_RX        3'h1
`define RSP_STATE_TX        3'h2
`define RSP_STATE_FAST_TX   3'h3
`define RSP_STATE_CAL       3'h4
`define RSP_STATE_SETTLE    3'h5
`define RSP_STATE_RX_OVF    3'h6
`define RSP_STATE_TX_UNF    3'h7

// kinds of event handed to the core
`define RSP_EVT_WRITE       2'h1
`define RSP_EVT_STROBE      2'h2

// index of the last bit of a byte on the link
`define RSP_BYTE_LAST       3'h7

`endif

// ### rsp_spi_slave.v
// four-wire serial slave port of the radio, with the chip status byte.
// assumes the link pins are asynchronous to clk and the link clock is slow
// enough (>= 4 clk per phase) to be sampled and edge detected by clk.
//
// How it works
// - four-wire slave port carrying register accesses and fifo data
// - every byte shifts most significant bit first
// - header is read/write bit, burst bit, six address bits
// - select rising mid header or mid access cancels that transfer
// - data-out driven low at select fall unless sleeping or oscillator off
// - status byte shifts out while header, data byte or strobe shifts in
// - status bit 7 is active-low ready, high until crystal stable
// - status bits 6:4 carry the main state code
// - transitional states may report idle instead of settle or calibrate
// - read header: low nibble is receive fifo bytes available
// - write header: low nibble is transmit fifo bytes free
// - fifo count saturates at fifteen
// - configuration registers take defaults on chip reset
// - writes return status per byte; reads return status only for header
// - burst loads an address counter stepping every eight clocks
// - header 3F/7F/BF/FF address the fifos single or burst
// - addresses 30..3D are status registers with burst, strobes without
`timescale 1ns/10ps
`default_nettype none
`include "rsp_consts.vh"

module rsp_spi_slave (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        chipSelectLow,
	input  wire        serialClk,
	input  wire        serialIn,
	output reg         serialOut,
	output wire        serialOutEnN,
	input  wire        oscillatorReadyN,
	input  wire [2:0]  mainState,
	input  wire [6:0]  rxFifoCount,
	input  wire [6:0]  txFifoFree,
	output reg         rdReq,
	output reg  [5:0]  rdAddr,
	output reg         rdStatusReg,
	input  wire [7:0]  rdData,
	output wire        evtValid,
	input  wire        evtReady,
	output wire [1:0]  evtKind,
	output wire [5:0]  evtAddr,
	output wire [7:0]  evtData,
	output wire        evtSpace,
	output reg         transferCancel
);

	localparam PH_HEADER = 2'h0;
	localparam PH_WRITE  = 2'h1;
	localparam PH_READ   = 2'h2;

	// *****************************************
	// helpers
	// *****************************************
	function [3:0] satCount;
		input [6:0] n;
		begin
			satCount = (n > 7'h0F) ? `RSP_ST_COUNT_SAT : n[3:0];
		end
	endfunction

	function inStatusRange;
		input [5:0] a;
		begin
			inStatusRange = (a >= `RSP_ADDR_STAT_LO) &&
				(a <= `RSP_ADDR_STAT_HI);
		end
	endfunction

	// *****************************************
	// pin synchronisers and edge detect
	// *****************************************
	reg [2:0] csSync_q;
	reg [2:0] ckSync_q;
	reg [1:0] siSync_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			csSync_q <= 3'h7;
			ckSync_q <= 3'h0;
			siSync_q <= 2'h0;
		end else begin
			csSync_q <= {csSync_q[1:0], chipSelectLow};
			ckSync_q <= {ckSync_q[1:0], serialClk};
			siSync_q <= {siSync_q[0], serialIn};
		end
	end

	wire csActive = ~csSync_q[1];
	wire csFall   = ~csSync_q[1] & csSync_q[2];
	wire csRise   = csSync_q[1] & ~csSync_q[2];
	wire ckRise   = csActive & ckSync_q[1] & ~ckSync_q[2];
	wire ckFall   = csActive & ~ckSync_q[1] & ckSync_q[2];

	// *****************************************
	// byte engine
	// *****************************************
	reg [1:0] phase_q;
	reg [2:0] bitCnt_q;
	reg [6:0] shiftIn_q;
	reg       rw_q;
	reg       burst_q;
	reg       dataSeen_q;
	reg [5:0] addr_q;
	reg [7:0] rdShift_q;
	reg       rdLoad_q;
	reg       pushReq;
	reg [1:0] pushKind;
	reg [5:0] pushAddr;
	reg [7:0] pushData;

	wire [7:0] inByte   = {shiftIn_q, siSync_q[1]};
	wire       byteDone = ckRise && (bitCnt_q == `RSP_BYTE_LAST);
	wire [2:0] outIdx   = 3'h7 - bitCnt_q;
	// rw of the header in progress is known once its first bit is in
	wire       rwNow    = (phase_q == PH_HEADER && bitCnt_q == 3'h0) ?
		1'b0 : rw_q;
	wire [7:0] statusByte = {oscillatorReadyN,
		mainState,
		rwNow ? satCount(rxFifoCount) : satCount(txFifoFree)};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q        <= PH_HEADER;
			dataSeen_q     <= 1'b0;
			bitCnt_q       <= 3'h0;
			shiftIn_q      <= 7'h00;
			rw_q           <= 1'b0;
			burst_q        <= 1'b0;
			addr_q         <= 6'h00;
			rdShift_q      <= 8'h00;
			rdLoad_q       <= 1'b0;
			rdReq          <= 1'b0;
			rdAddr         <= 6'h00;
			rdStatusReg    <= 1'b0;
			serialOut      <= 1'b1;
			transferCancel <= 1'b0;
			pushReq        <= 1'b0;
			pushKind       <= 2'h0;
			pushAddr       <= 6'h00;
			pushData       <= 8'h00;
		end else begin
			rdReq          <= 1'b0;
			pushReq        <= 1'b0;
			transferCancel <= 1'b0;
			rdLoad_q       <= rdReq;
			if (rdLoad_q)
				rdShift_q <= rdData;
			if (!csActive) begin
				phase_q    <= PH_HEADER;
				bitCnt_q   <= 3'h0;
				dataSeen_q <= 1'b0;
				// preloaded so the pin shows ready at once when driven
				serialOut  <= oscillatorReadyN;
				// partial header or data byte is dropped, never pushed;
				// a burst closed on a byte boundary after its first data byte ends normally
				if (csRise && (bitCnt_q != 3'h0 ||
					(phase_q != PH_HEADER && !dataSeen_q)))
					transferCancel <= 1'b1;
			end else begin
				if (csFall)
					serialOut <= oscillatorReadyN;
				if (ckFall) begin
					if (phase_q == PH_READ)
						serialOut <= rdShift_q[outIdx];
					else
						serialOut <= statusByte[outIdx];
				end
				if (ckRise) begin
					bitCnt_q  <= bitCnt_q + 3'h1;
					shiftIn_q <= inByte[6:0];
					if (phase_q == PH_HEADER && bitCnt_q == 3'h0)
						rw_q <= siSync_q[1];
				end
				if (byteDone) begin
					case (phase_q)
					PH_HEADER: begin
						dataSeen_q <= 1'b0;
						burst_q <= inByte[`RSP_HDR_BURST_BIT];
						addr_q  <= inByte[`RSP_HDR_ADDR_MSB:0];
						if (!inByte[`RSP_HDR_BURST_BIT] &&
							inStatusRange(inByte[5:0])) begin
							pushReq  <= 1'b1;
							pushKind <= `RSP_EVT_STROBE;
							pushAddr <= inByte[5:0];
							pushData <= 8'h00;
						end else if (inByte[`RSP_HDR_RW_BIT]) begin
							phase_q     <= PH_READ;
							rdReq       <= 1'b1;
							rdAddr      <= inByte[5:0];
							rdStatusReg <= inStatusRange(inByte[5:0]);
						end else begin
							phase_q <= PH_WRITE;
						end
					end
					PH_WRITE: begin
						pushReq  <= 1'b1;
						pushKind <= `RSP_EVT_WRITE;
						pushAddr <= addr_q;
						pushData <= inByte;
					end
					default: begin
					end
					endcase
					if (phase_q != PH_HEADER) begin
						dataSeen_q <= 1'b1;
						// fifo address stays put; status registers never burst
						if (burst_q && addr_q != `RSP_ADDR_FIFO &&
							!inStatusRange(addr_q))
							addr_q <= addr_q + 6'h01;
						if (!burst_q)
							phase_q <= PH_HEADER;
						else if (phase_q == PH_READ && !inStatusRange(addr_q)) begin
							rdReq       <= 1'b1;
							rdAddr      <= (addr_q != `RSP_ADDR_FIFO) ?
								addr_q + 6'h01 : addr_q;
							rdStatusReg <= 1'b0;
						end
					end
				end
			end
		end
	end

	// released while deselected, so several slaves can share the line
	assign serialOutEnN = ~csActive;

	// *****************************************
	// two-entry event buffer toward the core
	// *****************************************
	reg [15:0] evtMem_q [0:1];
	reg        wrPtr_q;
	reg        rdPtr_q;
	reg [1:0]  evtCnt_q;

	// a full buffer cannot stall the host's clock: the core must keep up
	assign evtSpace = (evtCnt_q != 2'h2);
	assign evtValid = (evtCnt_q != 2'h0);
	assign evtKind  = evtMem_q[rdPtr_q][15:14];
	assign evtAddr  = evtMem_q[rdPtr_q][13:8];
	assign evtData  = evtMem_q[rdPtr_q][7:0];

	wire doPush = pushReq & evtSpace;
	wire doPop  = evtValid & evtReady;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			evtMem_q[0] <= 16'h0000;
			evtMem_q[1] <= 16'h0000;
			wrPtr_q     <= 1'b0;
			rdPtr_q     <= 1'b0;
			evtCnt_q    <= 2'h0;
		end else begin
			if (doPush) begin
				evtMem_q[wrPtr_q] <= {pushKind, pushAddr, pushData};
				wrPtr_q           <= ~wrPtr_q;
			end
			if (doPop)
				rdPtr_q <= ~rdPtr_q;
			if (doPush && !doPop)
				evtCnt_q <= evtCnt_q + 2'h1;
			else if (doPop && !doPush)
				evtCnt_q <= evtCnt_q - 2'h1;
		end
	end

endmodule
`default_nettype wire

// ### rsp_spi_slave_properties.sv
// checker for the serial status port, on the top module's ports.
// assumes link clock phases of at least four clk cycles.
`timescale 1ns/10ps
`default_nettype none
module rsp_spi_slave_properties (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       chipSelectLow,
	input wire logic       serialClk,
	input wire logic       serialOut,
	input wire logic       serialOutEnN,
	input wire logic       oscillatorReadyN,
	input wire logic       rdReq,
	input wire logic       evtValid,
	input wire logic       evtReady,
	input wire logic       evtSpace,
	input wire logic       transferCancel,
	input wire logic [1:0] evtKind,
	input wire logic [5:0] evtAddr,
	input wire logic [7:0] evtData
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	off_release_a: assert property (
		chipSelectLow [*4] |-> serialOutEnN) else $error("pin driven");
	on_drive_a: assert property (
		!chipSelectLow [*4] |-> !serialOutEnN) else $error("pin released");
	ready_first_a: assert property (
		$fell(chipSelectLow) |-> ##[1:4] serialOut == oscillatorReadyN)
		else $error("ready bit late");
	out_hold_a: assert property (
		serialClk && $past(serialClk, 3) && !chipSelectLow
		|-> $stable(serialOut)) else $error("out moved");
	read_pulse_a: assert property (
		rdReq |-> !chipSelectLow ##1 !rdReq) else $error("bad read");
	cancel_pulse_a: assert property (
		transferCancel |-> chipSelectLow ##1 !transferCancel)
		else $error("bad cancel");
	event_hold_a: assert property (
		evtValid && !evtReady |=> evtValid
		&& $stable({evtKind, evtAddr, evtData})) else $error("head moved");
	full_head_a: assert property (
		!evtSpace && !evtReady |=> !evtSpace) else $error("full lost entry");
	cover property (rdReq);
	cover property (evtValid && evtReady && evtKind == 2'h2);
	cover property (transferCancel);
	cover property (!evtSpace);
endmodule
bind rsp_spi_slave rsp_spi_slave_properties chk (.*);
`default_nettype wire

// ### rsp_host_model.sv
// host master model: frames bytes with select, 160 ns link clock.
// assumes data-out is sampled only while selected.
`timescale 1ns/10ps
`default_nettype none
module rsp_host_model (
	output var logic chipSelectLow,
	output var logic serialClk,
	output var logic serialIn,
	input  wire logic serialOut,
	input  wire logic serialOutEnN
);
	logic lastOut = 1'b1;
	wire  lineIn;
	initial {chipSelectLow, serialClk, serialIn} = 3'h4;
	// a released line has no pull: it shows the inverse of its last level
	always @* begin
		if (!serialOutEnN)
			lastOut = serialOut;
	end
	assign lineIn = serialOutEnN ? !lastOut : serialOut;
	// drop select, then wait for data-out low
	task automatic open(output logic ok);
		#7 chipSelectLow = 0;
		ok = 0;
		for (int i = 0; i < 20 && !ok; i++)
			#20 ok = serialOutEnN === 1'b0 && lineIn === 1'b0;
	endtask
	// msb first, gap after each byte
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			serialIn = tx[i];
			#80 serialClk = 1;
			rx[i] = lineIn;
			#80 serialClk = 0;
		end
		#100;
	endtask
	// data-in moves after the frame; the slave must ignore it
	task automatic close;
		#80 chipSelectLow = 1;
		serialIn = !serialIn;
		#200;
	endtask
endmodule
`default_nettype wire

// ### test_rsp_spi_slave.sv
// self-checking bench: host model on the link, core side modelled here.
// assumes the host model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_rsp_spi_slave;
	logic clk = 0, rst_n = 0, oscillatorReadyN = 1, evtReady = 0, ok;
	logic stall = 0;
	logic [2:0] mainState = 0;
	logic [6:0] rxFifoCount = 0, txFifoFree = 0;
	logic [7:0] rdData = 0, b;
	logic [16:0] e, q[$];
	logic [31:0] rnd = 32'h3621BE00;
	wire chipSelectLow, serialClk, serialIn, serialOut, serialOutEnN;
	wire rdReq, rdStatusReg, evtValid, evtSpace, transferCancel;
	wire [1:0] evtKind;
	wire [5:0] rdAddr, evtAddr;
	wire [7:0] evtData;
	int errors = 0, checks = 0, cancels = 0, k;
	logic rdFirst = 0, stWant = 0;
	// strobe addresses of the two queue flushes, arbitrary picks
	localparam logic [5:0] FLUSH_RECEIVE_QUEUE_STROBE  = 6'h3A;
	localparam logic [5:0] FLUSH_TRANSMIT_QUEUE_STROBE = 6'h3B;
	rsp_spi_slave dut (.*);
	rsp_host_model host (.*);
	initial forever #10 clk = ~clk;
	function automatic [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [7:0] rdv(input [5:0] a);
		rdv = {a, 2'h1} ^ 8'hA5;
	endfunction
	task check(input logic [16:0] seen, want);
		checks++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		rnd <= nx(rnd);
		rdData <= rdv(rdAddr);
		evtReady <= !stall && rnd[3];
	end
	// strobes carry no data byte, so they hand over zero data
	always @(posedge clk) begin
		cancels <= cancels + transferCancel;
		if (rdReq) begin
			check(rdStatusReg, rdFirst && stWant);
			rdFirst = 0;
		end
		if (evtValid && evtReady) begin
			e = q.size() ? q.pop_front() : 17'h0;
			check({e[16], evtKind, evtAddr, evtData}, e);
		end
	end
	task automatic acc(input logic [7:0] h, input int n, input logic [7:0] d);
		logic [7:0] s, w;
		logic [6:0] c;
		logic [5:0] a;
		stWant = h[7:6] == 2'h3 && h[5:4] == 2'h3 && h[3:0] <= 4'hD;
		rdFirst = 1;
		c = h[7] ? rxFifoCount : txFifoFree;
		w = {1'b0, mainState, c > 15 ? 4'hF : c[3:0]};
		host.open(ok);
		check(ok, 1);
		if (n == 0 && h[5:4] == 2'h3)
			q.push_back({3'h6, h[5:0], 8'h0});
		host.xfer(h, s);
		check(s, w);
		for (int i = 0; i < n; i++) begin
			a = h[5:0] + 6'(h[6] && h[5:0] != 6'h3F ? i : 0);
			if (!h[7] && (!stall || i < 2))
				q.push_back({3'h1, a, 8'(d + i)});
			host.xfer(8'(d + i), s);
			check(s, h[7] ? rdv(a) : w);
		end
		host.close;
	endtask
	initial begin
		#2000000;
		errors++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		oscillatorReadyN <= 0;
		repeat (2) @(posedge clk);
		// idle after reset: the host rewrites a non-default frequency word
		acc(8'h0D, 1, rnd[15:8]);
		for (k = 0; k < 8; k++) begin
			@(posedge clk);
			mainState <= 3'(k);
			rxFifoCount <= k[0] ? rnd[6:0] : {3'h0, rnd[3:0]};
			txFifoFree <= k[1] ? rnd[14:8] : {3'h0, rnd[11:8]};
			@(posedge clk);
			b = {3'h0, rnd[20:16]};
			acc(b, 1, rnd[31:24]);
			acc(b | 8'h80, 1, 8'h0);
			acc(b | 8'hC0, 2, 8'h0);
			stall <= k == 3;
			acc(8'h7F, 3, rnd[7:0]);
			if (k == 3)
				check(evtSpace, 0);
			stall <= 0;
			acc(8'hBF, 1, 8'h0);
			acc(8'hFF, 2, 8'h0);
			acc(8'(8'hF0 | k), 1, 8'h0);
			if (k == 6)
				acc({2'h0, FLUSH_RECEIVE_QUEUE_STROBE}, 0, 8'h0);
			if (k == 7)
				acc({2'h0, FLUSH_TRANSMIT_QUEUE_STROBE}, 0, 8'h0);
			acc(8'(8'h30 | k | k << 7), 0, 8'h0);
			acc(b, 0, 8'h0);
		end
		for (k = 0; k < 500 && q.size() > 0; k++)
			@(posedge clk);
		check(q.size(), 0);
		check(cancels, 8);
		oscillatorReadyN <= 1;
		@(posedge clk);
		host.open(ok);
		check(ok, 0);
		host.close;
		print_verdict;
	end
endmodule
`default_nettype wire
